// ==== logic/microstep_sequencer.sv ====
// Microstep sequencer: step/direction in, serial ratio words out.
// Assumes an external shift/latch register and two phase drivers.
// What this block does
// - Direction plus three mode bits decode to sixteen states.
// - Modes: full, half, quarter, eighth, sixteenth, hold off, on, reset.
// - Format changes need no change of step clock rate.
// - All three mode bits high enter the soft reset state.
// - Reset pin low forces mode 0000 and single-phase detent.
// - Monitor low at single-phase full-step alignment, high otherwise.
// - Shift clock pin strap at power-up: high eighth, low sixteenth.
// - Then shift clock driven, data valid at rising edge, eight pulses.
// - Strobe rises after eight bits to latch the word.
// - Word: phase A code first, phase B code next.
// - Latched word refreshed once per eight step clocks.
// - Phase direction outputs change together with the strobed word.
// - Decay control picks mixed decay while a winding current falls.
// - Ratio, direction and decay come from position lookup tables.
// - Direction input sets forward or reverse sequencing.
`timescale 1ns/1ns
module microstep_sequencer (
   // System clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_rst_n,
   // Host step clock and static controls
   input  wire logic i_step_clk,
   input  wire logic i_dir,
   input  wire logic i_mode_select_hi,
   input  wire logic i_mode_select_mid,
   input  wire logic i_mode_select_lo,
   input  wire logic i_reset_pin_n,
   // Two-way shift clock pin
   input  wire logic i_sclk_in,
   output logic      o_sclk_out,
   output logic      o_sclk_oe,
   // Serial word to the latch
   output logic      o_serial_data,
   output logic      o_strobe,
   // Direct phase controls
   output logic      o_phase_dir_a,
   output logic      o_phase_dir_b,
   output logic      o_decay_ratio_ctrl_a,
   output logic      o_decay_ratio_ctrl_b,
   // Status
   output logic      o_monitor_n,
   output logic      o_sixteenth
);
   import microstep_pkg::*;

   // ************************************************************
   // Step clock domain
   // ************************************************************
   logic       step_rst_n;
   logic       step_dir;
   logic [2:0] step_mode;
   logic       step_toggle;

   sync_two_ff u_step_rst (
      .i_clk   (i_step_clk),
      .i_async (i_rst_n),
      .o_sync  (step_rst_n)
   );

   // Command taken on each rising step edge, announced by a toggle
   always_ff @(posedge i_step_clk) begin
      if (!step_rst_n) begin
         step_dir    <= 1'b0;
         step_mode   <= MODE_FULL;
         step_toggle <= 1'b0;
      end else begin
         step_dir    <= i_dir;
         step_mode   <= {i_mode_select_hi, i_mode_select_mid,
                         i_mode_select_lo};
         step_toggle <= ~step_toggle;
      end
   end

   // ************************************************************
   // Crossings into the system domain
   // ************************************************************
   logic toggle_sync;
   logic toggle_seen;
   logic pin_rst_n;
   logic sclk_sync;

   sync_two_ff u_tog (
      .i_clk   (i_sys_clk),
      .i_async (step_toggle),
      .o_sync  (toggle_sync)
   );
   sync_two_ff u_pin_rst (
      .i_clk   (i_sys_clk),
      .i_async (i_reset_pin_n),
      .o_sync  (pin_rst_n)
   );
   sync_two_ff u_sclk (
      .i_clk   (i_sys_clk),
      .i_async (i_sclk_in),
      .o_sync  (sclk_sync)
   );

   // Step data is stable for a whole step period, far longer
   // than the toggle takes to cross, so it is read directly
   wire step_event = toggle_sync ^ toggle_seen;

   // ************************************************************
   // Power-up strap of the shift clock pin
   // ************************************************************
   logic [3:0] strap_cnt;
   logic       strap_done;

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         strap_cnt   <= 4'h0;
         strap_done  <= 1'b0;
         o_sixteenth <= 1'b0;
         o_sclk_oe   <= 1'b0;
      end else if (!strap_done) begin
         strap_cnt <= strap_cnt + 4'h1;
         if (strap_cnt == STRAP_WAIT) begin
            strap_done  <= 1'b1;
            o_sixteenth <= ~sclk_sync;
            o_sclk_oe   <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Command decode
   // ************************************************************
   logic       dir_cur;
   logic [2:0] mode_cur;
   logic       disabled;
   logic [5:0] acc;
   logic [5:0] fmt_mask;
   logic [2:0] step_cnt;
   logic       load_pend;

   // Sixteen states: direction bit plus mode code
   wire is_step    = (step_mode <= MODE_SIXTEENTH);
   wire is_soft    = (step_mode == MODE_SOFT_RST);
   wire is_off     = (step_mode == MODE_HOLD_OFF);
   wire is_on      = (step_mode == MODE_HOLD_ON);
   wire hard_rst   = ~pin_rst_n;
   // Sixteenth request falls back to eighth on an eighth strap
   wire [5:0] mask_sel =
        (step_mode == MODE_FULL)    ? MASK_FULL    :
        (step_mode == MODE_HALF)    ? MASK_HALF    :
        (step_mode == MODE_QUARTER) ? MASK_QUARTER :
        (step_mode == MODE_EIGHTH || !o_sixteenth) ? MASK_EIGHTH :
        MASK_SIXTEENTH;
   // Fine position moves at a fixed rate per step clock, so any
   // format keeps the same full-step speed
   wire [5:0] inc     = o_sixteenth ? INC_SIXTEENTH : INC_EIGHTH;
   wire [5:0] acc_fwd = acc + inc;
   wire [5:0] acc_rev = acc - inc;
   wire [5:0] acc_nxt = step_dir ? acc_rev : acc_fwd;
   wire       advance = step_event & is_step & ~disabled;

   // Position, mode and hold state
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || hard_rst) begin
         dir_cur  <= 1'b0;
         mode_cur <= MODE_FULL;
         acc      <= POS_DETENT;
         fmt_mask <= MASK_FULL;
         disabled <= 1'b0;
      end else if (step_event) begin
         dir_cur  <= step_dir;
         mode_cur <= step_mode;
         if (is_soft) begin
            acc      <= POS_DETENT;
            fmt_mask <= MASK_FULL;
            disabled <= 1'b0;
         end else if (is_off) begin
            disabled <= 1'b1;
         end else if (is_on) begin
            disabled <= 1'b0;                // From present position
         end else if (advance) begin
            acc      <= acc_nxt;
            fmt_mask <= mask_sel;
         end
      end
   end

   // Toggle tracking; synchronous reset may copy the live value
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         toggle_seen <= toggle_sync;
      end else begin
         toggle_seen <= toggle_sync;
      end
   end

   // ************************************************************
   // Word reload scheduling
   // ************************************************************
   logic         sh_start;
   shift_state_t sh_state;
   wire force_load  = hard_rst | (step_event & (is_soft | is_off | is_on));
   wire eighth_step = step_event & (step_cnt == STEPS_PER_LOAD);

   // New request wins over the clear taken at start
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         step_cnt  <= 3'h0;
         load_pend <= 1'b1;                  // Detent word at power-up
      end else begin
         if (hard_rst || (step_event && is_soft)) begin
            step_cnt <= 3'h0;
         end else if (step_event) begin
            step_cnt <= step_cnt + 3'h1;
         end
         if (force_load || eighth_step) begin
            load_pend <= 1'b1;
         end else if (sh_start) begin
            load_pend <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Lookup tables on the quantised position
   // ************************************************************
   // Magnitude of cos(x * 5.625 deg) scaled to 15
   function automatic logic [3:0] ratio_mag(input logic [4:0] x);
      logic [3:0] m;
      m = 4'h0;
      case (x)
         5'h00, 5'h01, 5'h02: m = 4'hF;
         5'h03, 5'h04:        m = 4'hE;
         5'h05:               m = 4'hD;
         5'h06, 5'h07:        m = 4'hC;
         5'h08:               m = 4'hB;
         5'h09:               m = 4'hA;
         5'h0A:               m = 4'h8;
         5'h0B:               m = 4'h7;
         5'h0C:               m = 4'h6;
         5'h0D:               m = 4'h4;
         5'h0E:               m = 4'h3;
         5'h0F:               m = 4'h1;
         default:             m = 4'h0;
      endcase
      return m;
   endfunction : ratio_mag

   wire [5:0] pos   = acc & fmt_mask;
   wire [4:0] q_up  = {1'b0, pos[3:0]};
   wire [4:0] q_dn  = 5'h10 - q_up;
   // Phase A follows cos, phase B follows sin
   wire [3:0] mag_a = pos[4] ? ratio_mag(q_dn) : ratio_mag(q_up);
   wire [3:0] mag_b = pos[4] ? ratio_mag(q_up) : ratio_mag(q_dn);
   wire       sgn_a = (pos[5] == pos[4]);
   wire       sgn_b = ~pos[5];
   // Falling current: A in quadrants 0 and 2 going forward
   wire       dec_a = ~pos[4] ^ dir_cur;
   wire       dec_b = pos[4] ^ dir_cur;
   // A code first, B code next; three-bit codes pad low
   wire [7:0] word_4 = {mag_a, mag_b};
   wire [7:0] word_3 = {mag_a[3:1], mag_b[3:1], 2'h0};
   wire [7:0] word   = disabled ? 8'h00 :
                       (o_sixteenth ? word_4 : word_3);
   // Aligned single phase when the in-quadrant part is zero
   wire       mon_n  = (pos[3:0] != 4'h0);

   // ************************************************************
   // Serial shifter
   // ************************************************************
   logic [7:0] sh_word;
   logic [2:0] bit_idx;
   logic       hold_a;
   logic       hold_b;
   logic       hold_da;
   logic       hold_db;
   logic       hold_mon;

   assign sh_start = (sh_state == SH_IDLE) & load_pend & strap_done;

   // Three system cycles per bit keep data away from both edges
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         sh_state      <= SH_IDLE;
         sh_word       <= 8'h00;
         bit_idx       <= 3'h0;
         o_sclk_out    <= 1'b0;
         o_serial_data <= 1'b0;
         o_strobe      <= 1'b0;
      end else begin
         case (sh_state)
            SH_IDLE: begin
               if (sh_start) begin
                  sh_word       <= word;
                  o_serial_data <= word[7];
                  bit_idx       <= 3'h0;
                  sh_state      <= SH_HIGH;
               end
            end
            SH_HIGH: begin
               o_sclk_out <= 1'b1;
               sh_state   <= SH_FALL;
            end
            SH_FALL: begin
               o_sclk_out <= 1'b0;
               sh_state   <= (bit_idx == WORD_LAST_BIT) ? SH_STROBE
                                                        : SH_NEXT;
            end
            SH_NEXT: begin
               sh_word       <= {sh_word[6:0], 1'b0};
               o_serial_data <= sh_word[6];
               bit_idx       <= bit_idx + 3'h1;
               sh_state      <= SH_HIGH;
            end
            SH_STROBE: begin
               o_strobe <= 1'b1;
               sh_state <= SH_DONE;
            end
            SH_DONE: begin
               o_strobe <= 1'b0;
               sh_state <= SH_IDLE;
            end
            default: begin
               sh_state <= SH_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Direct outputs follow the word they belong to
   // ************************************************************
   // Snapshot with the word so a step during shifting cannot split them
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         hold_a   <= 1'b1;
         hold_b   <= 1'b1;
         hold_da  <= 1'b0;
         hold_db  <= 1'b0;
         hold_mon <= 1'b0;
      end else if (sh_start) begin
         hold_a   <= sgn_a;
         hold_b   <= sgn_b;
         hold_da  <= dec_a;
         hold_db  <= dec_b;
         hold_mon <= mon_n;
      end
   end

   // Updated on the strobe edge
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_phase_dir_a        <= 1'b1;
         o_phase_dir_b        <= 1'b1;
         o_decay_ratio_ctrl_a <= 1'b0;
         o_decay_ratio_ctrl_b <= 1'b0;
         o_monitor_n          <= 1'b0;
      end else if (sh_state == SH_STROBE) begin
         o_phase_dir_a        <= hold_a;
         o_phase_dir_b        <= hold_b;
         o_decay_ratio_ctrl_a <= hold_da;
         o_decay_ratio_ctrl_b <= hold_db;
         o_monitor_n          <= hold_mon;
      end
   end

endmodule : microstep_sequencer

// ==== logic/microstep_pkg.sv ====
// Constants and types shared by the microstep sequencer files.
// Assumes a 50 MHz system clock and a slow host step clock.
package microstep_pkg;

   // ************************************************************
   // Mode-select codes (direction is a separate bit)
   // ************************************************************
   localparam logic [2:0] MODE_FULL      = 3'h0;
   localparam logic [2:0] MODE_HALF      = 3'h1;
   localparam logic [2:0] MODE_QUARTER   = 3'h2;
   localparam logic [2:0] MODE_EIGHTH    = 3'h3;
   localparam logic [2:0] MODE_SIXTEENTH = 3'h4;
   localparam logic [2:0] MODE_HOLD_OFF  = 3'h5;
   localparam logic [2:0] MODE_HOLD_ON   = 3'h6;
   localparam logic [2:0] MODE_SOFT_RST  = 3'h7;

   // ************************************************************
   // Position quantisation masks, units of 1/16 full step
   // ************************************************************
   localparam logic [5:0] MASK_FULL      = 6'h30;
   localparam logic [5:0] MASK_HALF      = 6'h38;
   localparam logic [5:0] MASK_QUARTER   = 6'h3C;
   localparam logic [5:0] MASK_EIGHTH    = 6'h3E;
   localparam logic [5:0] MASK_SIXTEENTH = 6'h3F;
   localparam logic [5:0] INC_EIGHTH     = 6'h02;
   localparam logic [5:0] INC_SIXTEENTH  = 6'h01;

   // ************************************************************
   // Reset values and timing counts
   // ************************************************************
   localparam logic [5:0] POS_DETENT     = 6'h00;
   localparam logic [3:0] STRAP_WAIT     = 4'h8;  // Cycles before strap read
   localparam logic [2:0] WORD_LAST_BIT  = 3'h7;
   localparam logic [2:0] STEPS_PER_LOAD = 3'h7;  // Eighth event reloads

   // Serial shifter states
   typedef enum logic [2:0] {
      SH_IDLE, SH_HIGH, SH_FALL, SH_NEXT, SH_STROBE, SH_DONE
   } shift_state_t;

endpackage : microstep_pkg

// ==== logic/sync_two_ff.sv ====
// Two flip-flop synchroniser for one level.
// Assumes the input is a level held for several destination clocks.
`timescale 1ns/1ns
module sync_two_ff (
   // Clock
   input  wire logic i_clk,
   // Level in, level out
   input  wire logic i_async,
   output logic      o_sync
);
   logic stage1;

   // ************************************************************
   // First stage only feeds the second
   // ************************************************************
   always_ff @(posedge i_clk) begin
      stage1 <= i_async;
      o_sync <= stage1;
   end
endmodule : sync_two_ff

// ==== testbench/seq_props.sv ====
// Checker: serial port timing and direct output updates.
// Assumes a bind to the sequencer top; sees its ports only.
`timescale 1ns/1ns
module seq_props (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Serial side
   input wire logic o_sclk_out,
   input wire logic o_sclk_oe,
   input wire logic o_serial_data,
   input wire logic o_strobe,
   // Direct outputs and status
   input wire logic o_phase_dir_a,
   input wire logic o_phase_dir_b,
   input wire logic o_decay_ratio_ctrl_a,
   input wire logic o_decay_ratio_ctrl_b,
   input wire logic o_monitor_n,
   input wire logic o_sixteenth
);
   // ********
   // Helper counts
   // ********
   logic       sclk_q;
   logic [3:0] rises;
   logic [3:0] since_rst;
   wire  logic [4:0] direct = {o_phase_dir_a, o_phase_dir_b,
      o_decay_ratio_ctrl_a, o_decay_ratio_ctrl_b, o_monitor_n};
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   // Shift clock rises since the last strobe
   always_ff @(posedge i_sys_clk) begin
      sclk_q <= o_sclk_out;
      if (!i_rst_n || o_strobe) rises <= 4'h0;
      else if (o_sclk_out && !sclk_q) rises <= rises + 4'h1;
   end
   // Cycles since release, saturating so it never wraps
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) since_rst <= 4'h0;
      else if (since_rst != 4'hF) since_rst <= since_rst + 4'h1;
   end
   // ********
   // Properties
   // ********
   strobe_pulse_a: assert property (o_strobe |=> !o_strobe)
      else $error("strobe wider than one cycle");
   sclk_pulse_a: assert property ($rose(o_sclk_out) |=> !o_sclk_out)
      else $error("shift clock high too long");
   eight_bits_a: assert property ($rose(o_strobe) |-> rises == 4'h8)
      else $error("word not eight shift pulses");
   strobe_after_a: assert property ($rose(o_strobe) |->
      !o_sclk_out && !$past(o_sclk_out) && $past(o_sclk_out, 2))
      else $error("strobe not right after last bit");
   data_low_a: assert property ($changed(o_serial_data) |->
      !o_sclk_out && !$past(o_sclk_out))
      else $error("serial data moved near a clock high");
   sclk_idle_a: assert property (!o_sclk_oe |-> !o_sclk_out)
      else $error("shift clock active while not driven");
   strap_time_a: assert property ($rose(o_sclk_oe) |->
      since_rst >= 4'h8 && since_rst <= 4'hA)
      else $error("strap read at wrong time");
   strap_hold_a: assert property ($changed(o_sixteenth) |->
      $rose(o_sclk_oe))
      else $error("resolution changed outside strap");
   direct_sync_a: assert property ($changed(direct) |-> o_strobe)
      else $error("direct outputs moved without strobe");
   cover property ($rose(o_strobe));
   cover property ($rose(o_sclk_oe));
   cover property ($rose(o_monitor_n));
endmodule : seq_props

// ==== testbench/shift_latch_model.sv ====
// Latch model: serial-to-parallel register fed by the shift pin.
// Assumes the bench resolves the pin from enable and pull level.
`timescale 1ns/1ns
module shift_latch_model (
   // Pin levels at the latch
   input  wire logic       i_sclk_pin,
   input  wire logic       i_data,
   input  wire logic       i_strobe,
   // Parallel word and counts
   output logic [7:0] o_q,
   output logic [3:0] o_bits,
   output logic [7:0] o_words
);
   logic [7:0] shreg = 8'h00;
   logic [7:0] total = 8'h00;
   logic [7:0] base  = 8'h00;
   logic [7:0] cnt   = 8'h00;
   wire  logic [7:0] diff = total - base;
   assign o_words = cnt;
   // Bit taken on each rising shift clock, first bit ends on top
   always @(posedge i_sclk_pin) begin
      shreg <= {shreg[6:0], i_data};
      total <= total + 8'h01;
   end
   // Word moves to the outputs on the strobe's rising edge
   always @(posedge i_strobe) begin
      o_q    <= shreg;
      o_bits <= diff[3:0];
      base   <= total;
      cnt    <= cnt + 8'h01;
   end
endmodule : shift_latch_model

// ==== testbench/microstep_sequencer_bench.sv ====
// Bench for the microstep sequencer: steps, resets and strap reads.
// Assumes the package, the sequencer, checker and latch model.
`timescale 1ns/1ns
module microstep_sequencer_bench;
   import microstep_pkg::*;
   // ********
   // Stimulus, pins and tallies
   // ********
   localparam logic [3:0] MAG [0:16] = '{4'hF, 4'hF, 4'hF, 4'hE,
      4'hE, 4'hD, 4'hC, 4'hC, 4'hB, 4'hA, 4'h8, 4'h7, 4'h6, 4'h4,
      4'h3, 4'h1, 4'h0};
   logic       i_sys_clk     = 1'b0;
   logic       i_rst_n       = 1'b0;
   logic       i_step_clk    = 1'b0;
   logic       i_dir         = 1'b0;
   logic [2:0] mode          = 3'h0;
   logic       i_reset_pin_n = 1'b1;
   logic       pull_up       = 1'b0;
   logic       step_run      = 1'b1;
   logic       step_req      = 1'b0;
   logic       e16           = 1'b1;
   logic [5:0] fine          = 6'h00;
   logic [5:0] inc           = 6'h01;
   logic       sclk_out, sclk_oe, sdata, strobe, sixteenth;
   logic       pha, phb, dca, dcb, mon_n;
   logic [7:0] latch_q, words;
   logic [3:0] bits;
   wire  logic sclk_pin = sclk_oe ? sclk_out : pull_up;
   wire  logic [12:0] obs = {latch_q, pha, phb, dca, dcb, mon_n};
   int         err_total     = 0;
   int         checks_done   = 0;
   always #10 i_sys_clk = ~i_sys_clk;
   // Step clock: free while reset holds, then one edge per request
   always begin
      #7;
      if (step_run || step_req) i_step_clk = 1'b1;
      step_req = 1'b0;
      #8;
      i_step_clk = 1'b0;
   end
   microstep_sequencer dut (
      .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .i_step_clk(i_step_clk), .i_dir(i_dir),
      .i_mode_select_hi(mode[2]), .i_mode_select_mid(mode[1]),
      .i_mode_select_lo(mode[0]), .i_reset_pin_n(i_reset_pin_n),
      .i_sclk_in(sclk_pin), .o_sclk_out(sclk_out), .o_sclk_oe(sclk_oe),
      .o_serial_data(sdata), .o_strobe(strobe),
      .o_phase_dir_a(pha), .o_phase_dir_b(phb),
      .o_decay_ratio_ctrl_a(dca), .o_decay_ratio_ctrl_b(dcb),
      .o_monitor_n(mon_n), .o_sixteenth(sixteenth));
   shift_latch_model latch (
      .i_sclk_pin(sclk_pin), .i_data(sdata), .i_strobe(strobe),
      .o_q(latch_q), .o_bits(bits), .o_words(words));
   // ********
   // Expectations and tasks
   // ********
   // Word and direct outputs for a displayed position
   function automatic logic [12:0] expect_at(input logic [5:0] p,
                                             input logic d);
      logic [3:0] ca;
      logic [3:0] sb;
      logic [7:0] w;
      ca = p[4] ? MAG[16 - p[3:0]] : MAG[p[3:0]];
      sb = p[4] ? MAG[p[3:0]] : MAG[16 - p[3:0]];
      w = e16 ? {ca, sb} : {ca[3:1], sb[3:1], 2'h0};
      return {w, p[5] == p[4], !p[5], !p[4] ^ d, p[4] ^ d,
              p[3:0] != 4'h0};
   endfunction : expect_at
   // Grid of each stepping mode; sixteenth falls back on an eighth strap
   function automatic logic [5:0] dmask(input logic [2:0] m);
      case (m)
         MODE_FULL:    return MASK_FULL;
         MODE_HALF:    return MASK_HALF;
         MODE_QUARTER: return MASK_QUARTER;
         MODE_EIGHTH:  return MASK_EIGHTH;
         default:      return e16 ? MASK_SIXTEENTH : MASK_EIGHTH;
      endcase
   endfunction : dmask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic note(input string s);
      $display("test %s done", s);
   endtask : note
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test
   // Bounded wait for the next latched word, then let it settle
   task automatic wait_word(input logic [7:0] w0);
      int n;
      n = 0;
      while (words === w0 && n < 400) begin
         @(posedge i_sys_clk);
         n++;
      end
      if (n == 400) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, w0, w0 + 1);
         end_of_test();
      end
      @(posedge i_sys_clk);
      #3;
   endtask : wait_word
   // One command, then a gap wide enough for the step sync
   task automatic step(input logic [2:0] m, input logic d);
      @(posedge i_sys_clk);
      #3;
      mode = m;
      i_dir = d;
      step_req = 1'b1;
      repeat (8) @(posedge i_sys_clk);
   endtask : step
   // Steps that end in exactly one word at the new position
   task automatic run(input int n, input logic [2:0] m, input logic d);
      logic [7:0] w0;
      w0 = words;
      repeat (n) begin
         step(m, d);
         fine = d ? fine - inc : fine + inc;
      end
      wait_word(w0);
      cmp({3'h0, obs}, {3'h0, expect_at(fine & dmask(m), d)});
      cmp({4'h0, bits, words - w0}, {4'h0, 4'h8, 8'h01});
   endtask : run
   task automatic do_reset(input logic pull);
      @(posedge i_sys_clk);
      #3;
      pull_up = pull;
      i_rst_n = 1'b0;
      step_run = 1'b1;
      repeat (3) @(posedge i_sys_clk);
      #3;
      cmp({7'h0, sclk_oe, sclk_out, strobe, sixteenth, obs[4:0]},
          16'h0018);
      i_rst_n = 1'b1;
      // Step side leaves reset two step edges later; stop it then,
      // so no stray command is taken before the first request
      repeat (2) @(posedge i_step_clk);
      step_run = 1'b0;
      fine = POS_DETENT;
      e16 = !pull;
      inc = pull ? INC_EIGHTH : INC_SIXTEENTH;
      wait_word(words);
      cmp({14'h0, sixteenth, sclk_oe}, {14'h0, e16, 1'b1});
      cmp({3'h0, obs}, {3'h0, expect_at(POS_DETENT, 1'b0)});
   endtask : do_reset
   // ********
   // Test sequence
   // ********
   initial begin
      logic [7:0] w;
      do_reset(1'b0);
      note("reset and strap");
      run(8, MODE_SIXTEENTH, 1'b0);
      run(8, MODE_QUARTER, 1'b0);
      run(8, MODE_HALF, 1'b1);
      run(8, MODE_FULL, 1'b1);
      run(8, MODE_FULL, 1'b1);
      note("stepping");
      @(posedge i_sys_clk);
      #3;
      i_reset_pin_n = 1'b0;
      repeat (6) @(posedge i_sys_clk);
      #3;
      i_reset_pin_n = 1'b1;
      fine = POS_DETENT;
      repeat (60) @(posedge i_sys_clk);
      #3;
      cmp({3'h0, obs}, {3'h0, expect_at(POS_DETENT, 1'b0)});
      note("reset pin");
      w = words;
      step(MODE_HOLD_OFF, 1'b0);
      wait_word(w);
      cmp({8'h0, latch_q}, 16'h0000);
      repeat (4) step(MODE_SIXTEENTH, 1'b0);
      w = words;
      step(MODE_HOLD_ON, 1'b0);
      wait_word(w);
      cmp({3'h0, obs}, {3'h0, expect_at(POS_DETENT, 1'b0)});
      run(2, MODE_SIXTEENTH, 1'b0);
      w = words;
      step(MODE_SOFT_RST, 1'b1);
      wait_word(w);
      fine = POS_DETENT;
      cmp({3'h0, obs}, {3'h0, expect_at(POS_DETENT, 1'b1)});
      note("hold and soft reset");
      // One idle count first, so the seventh eighth step is the reload event;
      // it ends on the odd fine position 7 and the eighth grid must round it down
      w = words;
      step(MODE_HOLD_ON, 1'b0);
      wait_word(w);
      run(7, MODE_EIGHTH, 1'b0);
      note("eighth grid");
      do_reset(1'b1);
      run(8, MODE_SIXTEENTH, 1'b0);
      note("eighth strap");
      end_of_test();
   end
endmodule : microstep_sequencer_bench

bind microstep_sequencer seq_props chk (
   .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
   .o_sclk_out(o_sclk_out), .o_sclk_oe(o_sclk_oe),
   .o_serial_data(o_serial_data), .o_strobe(o_strobe),
   .o_phase_dir_a(o_phase_dir_a), .o_phase_dir_b(o_phase_dir_b),
   .o_decay_ratio_ctrl_a(o_decay_ratio_ctrl_a),
   .o_decay_ratio_ctrl_b(o_decay_ratio_ctrl_b),
   .o_monitor_n(o_monitor_n), .o_sixteenth(o_sixteenth));
